// ---- shared/uart_rx_pkg.sv ----
package uart_rx_pkg;
    // apb register byte offsets, one 32-bit word each
    localparam logic [7:0] OFF_RX_BUF = 8'h00;
    localparam logic [7:0] OFF_LINE_CTRL = 8'h04;
    localparam logic [7:0] OFF_LINE_STAT = 8'h08;
    localparam logic [7:0] OFF_DIVISOR = 8'h0C;
    localparam logic [7:0] OFF_FIFO_CTRL = 8'h10;
    localparam logic [7:0] OFF_MODEM_CTRL = 8'h14;
    // line_control fields
    localparam int LC_STOP2 = 2;
    localparam int LC_PAR_EN = 3;
    localparam int LC_PAR_EVEN = 4;
    // line_status fields
    localparam int LS_DR = 0;
    localparam int LS_OE = 1;
    localparam int LS_PE = 2;
    localparam int LS_FE = 3;
    localparam int LS_TX_HOLDING_EMPTY = 5;
    localparam int LS_TRANSMITTER_ALL_EMPTY = 6;
    // fifo control fields
    localparam int FC_EN = 0;
    localparam int FC_DMA1 = 3;
    localparam int FC_TRIG_LSB = 6;
    // modem_control fields and width
    localparam int MC_DTR = 0;
    localparam int MC_RTS = 1;
    localparam int MC_W = 5;
    // oversampling: mid start bit after 8 ticks, bit centre every 16
    localparam logic [3:0] MID_CNT = 4'h7;
    localparam logic [3:0] LAST_CNT = 4'hF;
    localparam logic [9:0] TICKS_PER_BIT = 10'h010;
    localparam logic [9:0] TMO_CHARS = 10'h004;
    localparam logic [2:0] FIRST_LEN_IDX = 3'h4;
    // receive fifo trigger levels
    localparam logic [4:0] TRIG_L0 = 5'h01;
    localparam logic [4:0] TRIG_L1 = 5'h04;
    localparam logic [4:0] TRIG_L2 = 5'h08;
    localparam logic [4:0] TRIG_L3 = 5'h0E;
    localparam int PTR_W = 4;

    typedef enum logic [2:0] {
        RX_IDLE = 3'b000,
        RX_START = 3'b001,
        RX_DATA = 3'b010,
        RX_PARITY = 3'b011,
        RX_STOP = 3'b100
    } rx_state_t;

    // one received character with its own error bits
    typedef struct packed {
        logic fe;
        logic pe;
        logic [7:0] data;
    } rx_entry_t;
endpackage

// ---- design/uart_rx_core.sv ----
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - idle receiver watches line for falling edge
// - edge restarts counter, mid start after 8 ticks
// - start kept only if still low
// - length, parity enable, polarity from line_control
// - full character sets data ready; read clears
// - unread character overwritten sets overrun flag
// - parity mismatch sets parity error flag
// - low stop bit sets framing error flag
// - fifo entries carry their own error bits
// - start lag one tick, centred bit samples
// - reset clears bit clock counters
// - reset clears status, modem control; sets empties
// - reset keeps line_control, divisor, buffers
// - mode 0: request low while fifo nonempty
// - mode 1: low at trigger/timeout, high empty
// - timeout after four idle character times
// - channel requests anded onto one pin
// - divisor divides clock into 16x tick
// - reset drives serial out, rts, dtr high
module uart_rx_core
    import uart_rx_pkg::*;
#(
    parameter int FIFO_DEPTH = 16,
    parameter int CHANNELS = 4
)
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic arst_n_i,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial line
    input wire logic serial_rx_in,
    output logic serial_tx_out,
    // modem outputs, active low
    output logic rts_n_o,
    output logic dtr_n_o,
    // dma requests of the other channels
    input wire logic [CHANNELS-2:0] peer_rx_dma_n_i,
    input wire logic [CHANNELS-2:0] peer_tx_dma_n_i,
    // combined dma request pins
    output logic rx_dma_request_n,
    output logic tx_dma_request_n
);
    // pointers wrap naturally only for a power of two up to 16
    if (FIFO_DEPTH != (1 << PTR_W) && FIFO_DEPTH != 8 && FIFO_DEPTH != 4)
        $error("FIFO_DEPTH must be 4, 8 or 16");
    if (CHANNELS < 2)
        $error("CHANNELS must be at least 2");

    localparam logic [4:0] DEPTH_C = 5'(FIFO_DEPTH);
    localparam logic [3:0] PTR_MASK = 4'(FIFO_DEPTH - 1);

    // reset-owned state of the channel
    typedef struct packed {
        rx_state_t st;
        logic [15:0] div_cnt;
        logic [3:0] samp;
        logic [2:0] bit_idx;
        logic rx_prev;
        logic [7:0] shift;
        logic par_acc;
        logic rx_par;
        logic [3:0] wr_ptr;
        logic [3:0] rd_ptr;
        logic [4:0] count;
        logic oe;
        logic pe;
        logic fe;
        logic [9:0] tmo_cnt;
        logic tmo;
        logic dma_req;
        logic pop_ok;
        logic [31:0] prdata;
        logic [MC_W-1:0] modem_control;
    } state_t;

    // settings that reset leaves alone
    typedef struct packed {
        logic [7:0] line_control;
        logic [15:0] div;
        logic [7:0] fcr;
    } cfg_t;

    state_t s_r; // registered state
    state_t s_nxt; // next state
    cfg_t c_r; // line_control, divisor, fifo control
    cfg_t c_nxt;
    rx_entry_t mem_r [FIFO_DEPTH]; // receive buffer, not reset
    rx_entry_t head; // entry at the read pointer
    rx_entry_t push_data; // character leaving the shift register
    logic [3:0] push_addr;
    logic push_we;
    logic tick; // 16x baud strobe
    logic push; // character complete
    logic pop; // cpu took the receive buffer
    logic setup; // apb setup cycle
    logic access; // apb access cycle
    logic hit; // address is mapped
    logic fifo_on;
    logic mode1;
    logic own_rx_n; // this channel's request, active low
    logic [4:0] trig;
    logic [9:0] frame_bits;
    logic [31:0] rd_mux;
    logic [7:0] lstat;

    assign head = mem_r[s_r.rd_ptr];
    assign fifo_on = c_r.fcr[FC_EN];
    assign mode1 = fifo_on & c_r.fcr[FC_DMA1];
    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign pready = 1'b1; // zero wait states
    assign prdata = s_r.prdata;
    assign serial_tx_out = 1'b1; // no transmitter here, line idles high
    assign rts_n_o = ~s_r.modem_control[MC_RTS];
    assign dtr_n_o = ~s_r.modem_control[MC_DTR];

    // divisor zero stops the tick rather than running at full rate
    assign tick = (c_r.div != 16'h0000) && (s_r.div_cnt >= c_r.div - 16'h0001);

    // decode for reads; unmapped words answer zero with an error
    always_comb
    begin
        hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            OFF_RX_BUF: rd_mux = {24'h00_0000, head.data};
            OFF_LINE_CTRL: rd_mux = {24'h00_0000, c_r.line_control};
            OFF_LINE_STAT: rd_mux = {24'h00_0000, lstat};
            OFF_DIVISOR: rd_mux = {16'h0000, c_r.div};
            OFF_FIFO_CTRL: rd_mux = {24'h00_0000, c_r.fcr};
            OFF_MODEM_CTRL: rd_mux = {27'h000_0000, s_r.modem_control};
            default: hit = 1'b0;
        endcase
    end
    assign pslverr = access & ~hit;

    // line status; fifo mode shows the head entry's own errors
    always_comb
    begin
        lstat = 8'h00;
        lstat[LS_DR] = (s_r.count != 5'h00);
        lstat[LS_OE] = s_r.oe;
        lstat[LS_PE] = fifo_on ? (head.pe & lstat[LS_DR]) : s_r.pe;
        lstat[LS_FE] = fifo_on ? (head.fe & lstat[LS_DR]) : s_r.fe;
        lstat[LS_TX_HOLDING_EMPTY] = 1'b1;
        lstat[LS_TRANSMITTER_ALL_EMPTY] = 1'b1;
    end

    // trigger level and frame length for the timeout
    always_comb
    begin
        case (c_r.fcr[FC_TRIG_LSB +: 2])
            2'b00: trig = TRIG_L0;
            2'b01: trig = TRIG_L1;
            2'b10: trig = TRIG_L2;
            default: trig = TRIG_L3;
        endcase
        // start + data + parity + stop(s)
        frame_bits = 10'h007 + {8'h00, c_r.line_control[1:0]} + {9'h000, c_r.line_control[LC_PAR_EN]}
            + {9'h000, c_r.line_control[LC_STOP2]};
    end

    // own request: mode 0 follows nonempty, mode 1 the latched request
    assign own_rx_n = mode1 ? ~s_r.dma_req : (s_r.count == 5'h00);
    // no transmitter in this channel, so its tx request stays released
    assign rx_dma_request_n = own_rx_n & (&peer_rx_dma_n_i);
    assign tx_dma_request_n = &peer_tx_dma_n_i;

    // receiver, fifo bookkeeping and bus side effects
    always_comb
    begin
        s_nxt = s_r;
        c_nxt = c_r;
        push = 1'b0;
        push_we = 1'b0;
        push_data = '0;
        push_addr = s_r.wr_ptr;
        pop = 1'b0;
        s_nxt.div_cnt = tick ? 16'h0000 : s_r.div_cnt + 16'h0001;
        if (tick)
        begin
            s_nxt.rx_prev = serial_rx_in;
            case (s_r.st)
                RX_IDLE:
                begin
                    // falling edge seen at a tick
                    if (s_r.rx_prev && !serial_rx_in)
                    begin
                        s_nxt.st = RX_START;
                        s_nxt.samp = 4'h0;
                    end
                end
                RX_START:
                begin
                    s_nxt.samp = s_r.samp + 4'h1;
                    // edge is at most one tick late, so tick 7 is mid bit
                    if (s_r.samp == MID_CNT)
                    begin
                        s_nxt.samp = 4'h0;
                        s_nxt.bit_idx = 3'h0;
                        s_nxt.shift = 8'h00;
                        s_nxt.par_acc = 1'b0;
                        // a high line here was a noise spike
                        s_nxt.st = serial_rx_in ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA:
                begin
                    s_nxt.samp = s_r.samp + 4'h1;
                    if (s_r.samp == LAST_CNT)
                    begin
                        s_nxt.shift[s_r.bit_idx] = serial_rx_in;
                        s_nxt.par_acc = s_r.par_acc ^ serial_rx_in;
                        s_nxt.bit_idx = s_r.bit_idx + 3'h1;
                        // last data bit depends on the length field
                        if (s_r.bit_idx == FIRST_LEN_IDX + {1'b0, c_r.line_control[1:0]})
                            s_nxt.st = c_r.line_control[LC_PAR_EN] ? RX_PARITY : RX_STOP;
                    end
                end
                RX_PARITY:
                begin
                    s_nxt.samp = s_r.samp + 4'h1;
                    if (s_r.samp == LAST_CNT)
                    begin
                        s_nxt.rx_par = serial_rx_in;
                        s_nxt.st = RX_STOP;
                    end
                end
                RX_STOP:
                begin
                    s_nxt.samp = s_r.samp + 4'h1;
                    // only the first stop bit is checked
                    if (s_r.samp == LAST_CNT)
                    begin
                        push = 1'b1;
                        push_data.data = s_r.shift;
                        push_data.fe = ~serial_rx_in;
                        push_data.pe = c_r.line_control[LC_PAR_EN]
                            & (s_r.par_acc ^ s_r.rx_par ^ ~c_r.line_control[LC_PAR_EVEN]);
                        s_nxt.st = RX_IDLE;
                    end
                end
                default: s_nxt.st = RX_IDLE;
            endcase
        end

        // apb setup: capture read data and whether a pop is allowed
        if (setup && !pwrite)
        begin
            s_nxt.prdata = rd_mux;
            s_nxt.pop_ok = (s_r.count != 5'h00);
        end

        // apb access: writes and read side effects take effect here
        if (access && pwrite)
        begin
            case (paddr)
                OFF_LINE_CTRL: if (pstrb[0]) c_nxt.line_control = pwdata[7:0];
                OFF_DIVISOR:
                begin
                    // restart the baud count so the new divisor starts from a zero count
                    s_nxt.div_cnt = 16'h0000;
                    if (pstrb[0]) c_nxt.div[7:0] = pwdata[7:0];
                    if (pstrb[1]) c_nxt.div[15:8] = pwdata[15:8];
                end
                OFF_FIFO_CTRL: if (pstrb[0]) c_nxt.fcr = pwdata[7:0];
                OFF_MODEM_CTRL: if (pstrb[0]) s_nxt.modem_control = pwdata[MC_W-1:0];
                default: ;
            endcase
        end
        if (access && !pwrite && paddr == OFF_RX_BUF && s_r.pop_ok)
            pop = 1'b1;
        // only bits the cpu actually saw are cleared, so a new event survives
        if (access && !pwrite && paddr == OFF_LINE_STAT)
        begin
            s_nxt.oe = s_r.oe & ~s_r.prdata[LS_OE];
            s_nxt.pe = s_r.pe & ~s_r.prdata[LS_PE];
            s_nxt.fe = s_r.fe & ~s_r.prdata[LS_FE];
        end

        // store the character; set wins over any clear above
        if (push)
        begin
            if (fifo_on)
            begin
                if (s_r.count == DEPTH_C)
                    s_nxt.oe = 1'b1; // full fifo drops the new character
                else
                begin
                    push_we = 1'b1;
                end
            end
            else
            begin
                push_we = 1'b1;
                s_nxt.pe = s_nxt.pe | push_data.pe;
                s_nxt.fe = s_nxt.fe | push_data.fe;
                if (s_r.count != 5'h00 && !pop)
                begin
                    s_nxt.oe = 1'b1; // unread holding byte is overwritten
                    push_addr = s_r.rd_ptr;
                end
            end
        end
        if (push_we && push_addr == s_r.wr_ptr)
            s_nxt.wr_ptr = (s_r.wr_ptr + 4'h1) & PTR_MASK;
        if (pop)
            s_nxt.rd_ptr = (s_r.rd_ptr + 4'h1) & PTR_MASK;
        s_nxt.count = s_r.count + {4'h0, push_we && push_addr == s_r.wr_ptr}
            - {4'h0, pop};

        // character timeout counts ticks while data waits
        if (s_nxt.count == 5'h00 || push || pop || !fifo_on)
        begin
            s_nxt.tmo_cnt = 10'h000;
            s_nxt.tmo = 1'b0;
        end
        else if (tick && !s_r.tmo)
        begin
            s_nxt.tmo_cnt = s_r.tmo_cnt + 10'h001;
            if (s_r.tmo_cnt + 10'h001 >= 10'(TMO_CHARS * TICKS_PER_BIT * frame_bits))
                s_nxt.tmo = 1'b1;
        end

        // mode 1 request: set at trigger or timeout, cleared only when empty
        if (s_nxt.count == 5'h00)
            s_nxt.dma_req = 1'b0;
        else if (s_r.count >= trig || s_r.tmo)
            s_nxt.dma_req = 1'b1;
    end

    // reset state: counters, status, modem control
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            s_r <= '0;
            s_r.st <= RX_IDLE;
            s_r.rx_prev <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // settings survive reset; software must program them after power up
    always_ff @(posedge mclk_i)
    begin
        c_r <= c_nxt;
    end

    // receive buffer storage, untouched by reset
    always_ff @(posedge mclk_i)
    begin
        if (push_we)
            mem_r[push_addr] <= push_data;
    end

    // checks
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence s_edge;
        s_r.st == RX_IDLE && tick && s_r.rx_prev && !serial_rx_in;
    endsequence
    sequence s_mid_high;
        s_r.st == RX_START && tick && s_r.samp == MID_CNT && serial_rx_in;
    endsequence

    chk_edge_start: assert property (s_edge |=> s_r.st == RX_START && s_r.samp == 4'h0)
        else $error("falling edge did not start the start bit check");
    chk_noise_reject: assert property (s_mid_high |=> s_r.st == RX_IDLE && !push)
        else $error("high mid start sample did not return to idle");
    chk_data_ready: assert property (push_we && s_r.count == 5'h00 && !pop |=> lstat[LS_DR])
        else $error("stored character did not raise data ready");
    chk_read_clear: assert property (pop && s_r.count == 5'h01 && !push |=> !lstat[LS_DR])
        else $error("reading the last character left data ready set");
    chk_overrun_set: assert property (push && !fifo_on && s_r.count != 5'h00 && !pop |=> s_r.oe)
        else $error("overwrite did not set overrun");
    chk_frame_err: assert property (push && !fifo_on && !serial_rx_in |=> s_r.fe)
        else $error("low stop bit did not set framing error");
    chk_parity_err: assert property (push && !fifo_on && c_r.line_control[LC_PAR_EN]
        && (s_r.par_acc ^ s_r.rx_par ^ ~c_r.line_control[LC_PAR_EVEN]) |=> s_r.pe)
        else $error("parity mismatch did not set parity error");
    chk_mode0_req: assert property (!mode1 |-> own_rx_n == (s_r.count == 5'h00))
        else $error("mode 0 request does not follow fifo occupancy");
    chk_mode1_hold: assert property (mode1 && !own_rx_n && s_nxt.count != 5'h00
        && $stable(c_r.fcr) |=> !own_rx_n)
        else $error("mode 1 request released before fifo emptied");
    chk_tick_gap: assert property (tick && c_r.div > 16'h0001 && $stable(c_r.div)
        && !(access && pwrite && paddr == OFF_DIVISOR) |=> !tick)
        else $error("16x tick faster than the divisor allows");
endmodule
`default_nettype wire

// ---- tb/uart_line_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module uart_line_model
(
    // bench clock
    input wire logic clk_i,
    // serial line into the receiver, idles high
    output var logic line_o
);
    // clocks per bit: 16 ticks at divisor one
    int bit_clks = 16;

    initial line_o = 1'b1;

    // one level for n clocks, changed just after an edge
    task automatic hold(input logic v, input int n);
        line_o <= v;
        repeat (n) @(posedge clk_i);
    endtask

    // frame: start, data lsb first, parity if cfg[0], one stop
    // cfg[1] even parity, cfg[2] corrupt parity, cfg[3] low stop bit
    task automatic send(input logic [7:0] d, input int nb, input logic [3:0] cfg);
        logic p;
        p = ^(d & 8'((1 << nb) - 1)) ^ ~cfg[1] ^ cfg[2];
        hold(1'b0, bit_clks);
        for (int i = 0; i < nb; i++)
            hold(d[i], bit_clks);
        if (cfg[0])
            hold(p, bit_clks);
        hold(~cfg[3], bit_clks);
        // idle gap so the next start edge follows a high level
        hold(1'b1, 2 * bit_clks);
    endtask

    // lone low pulse of n clocks, then idle
    task automatic pulse(input int n);
        hold(1'b0, n);
        hold(1'b1, 2 * bit_clks);
    endtask
endmodule
`default_nettype wire

// ---- tb/uart_receiver_reset_dma_ready_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module uart_receiver_reset_dma_ready_tb
    import uart_rx_pkg::*;
;
    // clock, reset and apb master side
    logic mclk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, serial_rx_in, serial_tx_out, rts_n_o, dtr_n_o;
    // other channels idle until a test drives them
    logic [2:0] peer_rx_dma_n_i = 3'h7, peer_tx_dma_n_i = 3'h7;
    logic rx_dma_request_n, tx_dma_request_n;
    int err_total = 0, tests_run = 0;
    logic [31:0] seed = 32'h086E;
    logic [7:0] sent [4];

    uart_rx_core #(.FIFO_DEPTH(16), .CHANNELS(4)) uart_rx_core_i (
        .mclk_i, .arst_n_i, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hF), .prdata, .pready, .pslverr, .serial_rx_in, .serial_tx_out,
        .rts_n_o, .dtr_n_o, .peer_rx_dma_n_i, .peer_tx_dma_n_i,
        .rx_dma_request_n, .tx_dma_request_n
    );

    uart_line_model uart_line_model_i (.clk_i(mclk_i), .line_o(serial_rx_in));

    initial forever #4 mclk_i = ~mclk_i;

    // repeatable pseudo random source
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // expected line_status; both transmitter empties always read 1
    function automatic logic [31:0] line_status(input logic dr, oe, pe, fe);
        return {24'h0, 4'h6, fe, pe, oe, dr};
    endfunction

    // expected data of an nb-bit character
    function automatic logic [31:0] masked(input logic [7:0] d, input int nb);
        return {24'h0, d & 8'((1 << nb) - 1)};
    endfunction

    task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_pin(input string nm, input logic e, input logic g);
        tests_run++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask

    // one apb transfer; request held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        int n = 0;
        // an idle edge first, so psel is never set twice in one step
        @(posedge mclk_i);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk_i);
        penable <= 1'b1;
        @(posedge mclk_i);
        while (pready !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge mclk_i);
        end
        if (n == 50)
            err_total++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic er;
        apb(1'b1, a, d, r, er);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        logic er;
        apb(1'b0, a, 32'h0, r, er);
        chk_val(nm, e, r);
    endtask

    // frame sent whole, then a few clocks for the flags to land
    task automatic rx(input logic [7:0] d, input int nb, input logic [3:0] cfg);
        uart_line_model_i.send(d, nb, cfg);
        repeat (4) @(posedge mclk_i);
    endtask

    // let pops and writes of the last edge settle before looking
    task automatic dma_is(input logic e);
        @(posedge mclk_i);
        chk_pin("rx_dma_request_n", e, rx_dma_request_n);
    endtask

    // random peer requests: either pin is low if any channel asks
    task automatic peers(input logic own);
        logic [31:0] r;
        repeat (4)
        begin
            r = xs();
            peer_rx_dma_n_i <= r[2:0];
            peer_tx_dma_n_i <= r[5:3];
            @(posedge mclk_i);
            @(posedge mclk_i);
            chk_pin("rx_dma_request_n", own & (&r[2:0]), rx_dma_request_n);
            chk_pin("tx_dma_request_n", &r[5:3], tx_dma_request_n);
        end
        peer_rx_dma_n_i <= 3'h7;
        peer_tx_dma_n_i <= 3'h7;
    endtask

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        logic [31:0] r;
        logic [3:0] cfg;
        int nb;
        repeat (4) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        rd_chk("line_status", OFF_LINE_STAT, line_status(0, 0, 0, 0));
        chk_pin("serial_tx_out", 1'b1, serial_tx_out);
        chk_pin("rts_n_o", 1'b1, rts_n_o);
        chk_pin("dtr_n_o", 1'b1, dtr_n_o);
        $display("test reset_values done");
        // config is not reset, so program it before any traffic
        wr(OFF_DIVISOR, 32'h1);
        wr(OFF_FIFO_CTRL, 32'h0);
        // every length and parity mode, random data and faults
        for (int i = 0; i < 16; i++)
        begin
            r = xs();
            nb = 5 + i % 4;
            cfg = {r[9] & r[10], i[2] & r[8], i[3], i[2]};
            wr(OFF_LINE_CTRL, {27'h0, i[3], i[2], 1'b0, i[1:0]});
            rx(r[23:16], nb, cfg);
            rd_chk("line_status", OFF_LINE_STAT, line_status(1, 0, cfg[2], cfg[3]));
            rd_chk("receive_buffer", OFF_RX_BUF, masked(r[23:16], nb));
            rd_chk("line_status", OFF_LINE_STAT, line_status(0, 0, 0, 0));
        end
        // slower tick: bits twice as long must still be centred
        wr(OFF_DIVISOR, 32'h2);
        uart_line_model_i.bit_clks = 32;
        rx(8'h6B, 8, 4'h3);
        rd_chk("receive_buffer", OFF_RX_BUF, 32'h6B);
        wr(OFF_DIVISOR, 32'h1);
        uart_line_model_i.bit_clks = 16;
        $display("test frames done");
        wr(OFF_LINE_CTRL, 32'h03);
        rx(8'hA5, 8, 4'h0);
        rx(8'h3C, 8, 4'h0);
        rd_chk("line_status", OFF_LINE_STAT, line_status(1, 1, 0, 0));
        rd_chk("receive_buffer", OFF_RX_BUF, 32'h3C);
        $display("test overrun done");
        // short pulse is noise; one past mid start is a start bit
        uart_line_model_i.pulse(6);
        rd_chk("line_status", OFF_LINE_STAT, line_status(0, 0, 0, 0));
        uart_line_model_i.pulse(10);
        uart_line_model_i.hold(1'b1, 160);
        rd_chk("line_status", OFF_LINE_STAT, line_status(1, 0, 0, 0));
        rd_chk("receive_buffer", OFF_RX_BUF, 32'hFF);
        $display("test start_check done");
        wr(OFF_FIFO_CTRL, 32'h01);
        dma_is(1'b1);
        wr(OFF_LINE_CTRL, 32'h0B);
        rx(8'h5A, 8, 4'h5);
        rx(8'hC3, 8, 4'h1);
        dma_is(1'b0);
        peers(1'b0);
        rd_chk("line_status", OFF_LINE_STAT, line_status(1, 0, 1, 0));
        rd_chk("receive_buffer", OFF_RX_BUF, 32'h5A);
        rd_chk("line_status", OFF_LINE_STAT, line_status(1, 0, 0, 0));
        rd_chk("receive_buffer", OFF_RX_BUF, 32'hC3);
        dma_is(1'b1);
        peers(1'b1);
        $display("test dma_mode0 done");
        // trigger level four: low only once the fourth byte lands
        wr(OFF_FIFO_CTRL, 32'h49);
        wr(OFF_LINE_CTRL, 32'h03);
        for (int i = 0; i < 4; i++)
        begin
            dma_is(1'b1);
            r = xs();
            sent[i] = r[7:0];
            rx(sent[i], 8, 4'h0);
        end
        for (int i = 0; i < 4; i++)
        begin
            dma_is(1'b0);
            rd_chk("receive_buffer", OFF_RX_BUF, {24'h0, sent[i]});
        end
        dma_is(1'b1);
        // one byte below trigger: request waits four 10-bit characters
        rx(8'h96, 8, 4'h0);
        repeat (500) @(posedge mclk_i);
        dma_is(1'b1);
        for (int n = 0; n < 300 && rx_dma_request_n !== 1'b0; n++)
            @(posedge mclk_i);
        dma_is(1'b0);
        rd_chk("receive_buffer", OFF_RX_BUF, 32'h96);
        dma_is(1'b1);
        $display("test dma_mode1 done");
        // reset in mid run with data waiting and modem lines active
        wr(OFF_MODEM_CTRL, 32'h03);
        @(posedge mclk_i);
        chk_pin("rts_n_o", 1'b0, rts_n_o);
        rx(8'h42, 8, 4'h0);
        wr(OFF_LINE_CTRL, 32'h1B);
        @(posedge mclk_i);
        arst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        chk_pin("rts_n_o", 1'b1, rts_n_o);
        chk_pin("dtr_n_o", 1'b1, dtr_n_o);
        arst_n_i <= 1'b1;
        dma_is(1'b1);
        rd_chk("line_status", OFF_LINE_STAT, line_status(0, 0, 0, 0));
        rd_chk("modem_control", OFF_MODEM_CTRL, 32'h0);
        rd_chk("line_control", OFF_LINE_CTRL, 32'h1B);
        rd_chk("divisor", OFF_DIVISOR, 32'h1);
        rx(8'h81, 8, 4'h3);
        rd_chk("receive_buffer", OFF_RX_BUF, 32'h81);
        $display("test mid_reset done");
        // unmapped offset is refused and reads as zero
        apb(1'b0, 8'h18, 32'h0, r, cfg[0]);
        chk_val("unmapped_data", 32'h0, r);
        chk_pin("unmapped_error", 1'b1, cfg[0]);
        $display("test unmapped done");
        tally_and_finish();
    end

    // hang guard, well above the expected run length
    initial
    begin
        repeat (40000) @(posedge mclk_i);
        err_total++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
